//--- iec_top.sv
// Interrupt edge select, enable and request flag registers.
// Assumes a single clock, synchronous pins and a one-cycle register port.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module iec_top
  import iec_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic [AW-1:0]           addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    wr_stb,
  input  wire logic                    rd_stb,
  output logic      [7:0]              rdata,
  input  wire logic [NUM_REQ_PINS-1:0] req_pin,
  input  wire logic [NUM_EXT_PINS-1:0] ext_pin,
  input  wire logic                    timer_b1_ovf,
  input  wire logic                    timer_a_ovf,
  input  wire logic [7:0]              set_two,
  input  wire logic [7:0]              set_three,
  input  wire logic                    cpu_mask,
  output logic                         timer_y_clock_edge,
  output logic                         timer_b_clock_edge,
  output logic                         converter_trigger_edge,
  output logic [7:0]                   pending_one,
  output logic [7:0]                   pending_two,
  output logic [7:0]                   pending_three,
  output logic                         cpu_irq
);
  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  logic [7:0] irq_pin_edge_select_r;
  logic [7:0] ext_pin_edge_select_r;
  logic [7:0] request_enable_one_r;
  logic [7:0] request_enable_two_r;
  logic [7:0] request_enable_three_r;
  logic [7:0] request_flags_one;
  logic [7:0] request_flags_two;
  logic [7:0] request_flags_three;
  logic [NUM_REQ_PINS-1:0] req_edge;
  logic [NUM_EXT_PINS-1:0] ext_edge;
  logic [7:0] set_one;

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_pin_edge_select_r <= RST_EDGE_ONE;
      ext_pin_edge_select_r <= RST_EDGE_TWO;
    end else if (wr_stb && addr == ADDR_EDGE_ONE) begin
      // Fixed bits keep their reset value.
      irq_pin_edge_select_r <= (wdata & WM_EDGE_ONE) | (RST_EDGE_ONE & ~WM_EDGE_ONE);
    end else if (wr_stb && addr == ADDR_EDGE_TWO) begin
      ext_pin_edge_select_r <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      request_enable_one_r   <= RST_EN_ONE;
      request_enable_two_r   <= RST_EN_TWO;
      request_enable_three_r <= RST_EN_THREE;
    end else if (wr_stb && addr == ADDR_EN_ONE) begin
      request_enable_one_r <= (wdata & WM_EN_ONE) | (RST_EN_ONE & ~WM_EN_ONE);
    end else if (wr_stb && addr == ADDR_EN_TWO) begin
      request_enable_two_r <= wdata & WM_EN_TWO;
    end else if (wr_stb && addr == ADDR_EN_THREE) begin
      request_enable_three_r <= wdata;
    end
  end

  // ****************************************************************
  // Edge detection
  // ****************************************************************
  iec_edge_detect #(.N(NUM_REQ_PINS)) u_req_edge (
    .clk        (clk),
    .rst        (rst),
    .pin        (req_pin),
    .rise_sel   (irq_pin_edge_select_r[NUM_REQ_PINS-1:0]),
    .edge_pulse (req_edge)
  );

  iec_edge_detect #(.N(NUM_EXT_PINS)) u_ext_edge (
    .clk        (clk),
    .rst        (rst),
    .pin        (ext_pin),
    .rise_sel   (ext_pin_edge_select_r),
    .edge_pulse (ext_edge)
  );

  // Shared pins feed the timers and converter with the same selected edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_y_clock_edge     <= 1'b0;
      timer_b_clock_edge     <= 1'b0;
      converter_trigger_edge <= 1'b0;
    end else begin
      timer_y_clock_edge     <= ext_edge[BIT_TIMER_Y];
      timer_b_clock_edge     <= ext_edge[BIT_TIMER_B];
      converter_trigger_edge <= ext_edge[BIT_CONV_TRIG];
    end
  end

  // ****************************************************************
  // Request flags
  // ****************************************************************
  always_comb begin
    set_one = 8'h00;
    set_one[BIT_TB1] = timer_b1_ovf;
    set_one[BIT_TA]  = timer_a_ovf;
    set_one[NUM_REQ_PINS-1:0] = req_edge;
  end

  iec_flag_reg #(.RST_VAL(RST_FLAG_ONE), .WMASK(WM_FLAG_ONE)) u_flag_one (
    .clk     (clk),
    .rst     (rst),
    .wr      (wr_stb && addr == ADDR_FLAG_ONE),
    .wdata   (wdata),
    .set     (set_one),
    .flags_r (request_flags_one)
  );

  iec_flag_reg #(.RST_VAL(RST_FLAG_TWO), .WMASK(WM_FLAG_TWO)) u_flag_two (
    .clk     (clk),
    .rst     (rst),
    .wr      (wr_stb && addr == ADDR_FLAG_TWO),
    .wdata   (wdata),
    .set     (set_two),
    .flags_r (request_flags_two)
  );

  iec_flag_reg #(.RST_VAL(RST_FLAG_THREE), .WMASK(WM_ALL)) u_flag_three (
    .clk     (clk),
    .rst     (rst),
    .wr      (wr_stb && addr == ADDR_FLAG_THREE),
    .wdata   (wdata),
    .set     (set_three | ext_edge),
    .flags_r (request_flags_three)
  );

  // ****************************************************************
  // Requests to the CPU
  // ****************************************************************
  // Flag bit 4 of the first set reads 1 but has no enable, so it is masked.
  always_comb begin
    pending_one   = request_flags_one & request_enable_one_r & WM_FLAG_ONE;
    pending_two   = request_flags_two & request_enable_two_r;
    pending_three = request_flags_three & request_enable_three_r;
  end

  // The mask stops acceptance only; flags keep collecting.
  assign cpu_irq = ~cpu_mask & (|{pending_one, pending_two, pending_three});

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_stb) begin
      if (addr == ADDR_EDGE_ONE) begin
        rdata <= irq_pin_edge_select_r;
      end else if (addr == ADDR_EDGE_TWO) begin
        rdata <= ext_pin_edge_select_r;
      end else if (addr == ADDR_EN_ONE) begin
        rdata <= request_enable_one_r;
      end else if (addr == ADDR_EN_TWO) begin
        rdata <= request_enable_two_r;
      end else if (addr == ADDR_EN_THREE) begin
        rdata <= request_enable_three_r;
      end else if (addr == ADDR_FLAG_ONE) begin
        rdata <= request_flags_one;
      end else if (addr == ADDR_FLAG_TWO) begin
        rdata <= request_flags_two;
      end else if (addr == ADDR_FLAG_THREE) begin
        rdata <= request_flags_three;
      end else begin
        rdata <= 8'h00;
      end
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule
`default_nettype wire

//--- iec_pkg.sv
// Constants for the interrupt edge and enable control block.
// Assumes a single 125 MHz clock and a plain one-cycle register port.
//
// How it works
// - Edge selects FFF2-3, enables FFF4-6, eight bits.
// - Flag registers FFF7-9, reset 10, 00, 00.
// - Flag writes only clear; ones leave flags.
// - First edge select resets to 70.
// - First edge select bit 7 reads 0.
// - First edge select bits 6-4 read 1.
// - Bits 3-0 pick request pin edge; 0 falling.
// - Second edge select resets to 00, falling.
// - Bit 7 edges pin 7 and timer Y.
// - Bit 6 edges pin 6 and timer B.
// - Bit 5 edges pin 5 and converter trigger.
// - Bits 4-0 edge external pins 4-0.
// - First enable resets to 10, all disabled.
// - Enable bit 7 gates timer B1 overflow.
// - Enable bit 6 gates timer A overflow.
// - First enable bit 5 reads 0.
// - First enable bit 4 reads 1.
// - Enable bits 3-0 gate request pins 3-0.
// - Flags stay set until software writes 0.
// - CPU mask blocks acceptance, flags still set.
package iec_pkg;
  localparam int          AW               = 16;
  localparam logic [15:0] ADDR_EDGE_ONE    = 16'hfff2;
  localparam logic [15:0] ADDR_EDGE_TWO    = 16'hfff3;
  localparam logic [15:0] ADDR_EN_ONE      = 16'hfff4;
  localparam logic [15:0] ADDR_EN_TWO      = 16'hfff5;
  localparam logic [15:0] ADDR_EN_THREE    = 16'hfff6;
  localparam logic [15:0] ADDR_FLAG_ONE    = 16'hfff7;
  localparam logic [15:0] ADDR_FLAG_TWO    = 16'hfff8;
  localparam logic [15:0] ADDR_FLAG_THREE  = 16'hfff9;
  localparam logic [7:0]  RST_EDGE_ONE     = 8'h70;
  localparam logic [7:0]  RST_EDGE_TWO     = 8'h00;
  localparam logic [7:0]  RST_EN_ONE       = 8'h10;
  localparam logic [7:0]  RST_EN_TWO       = 8'h00;
  localparam logic [7:0]  RST_EN_THREE     = 8'h00;
  localparam logic [7:0]  RST_FLAG_ONE     = 8'h10;
  localparam logic [7:0]  RST_FLAG_TWO     = 8'h00;
  localparam logic [7:0]  RST_FLAG_THREE   = 8'h00;
  // Writable bit masks; other bits are fixed at their reset value.
  localparam logic [7:0]  WM_EDGE_ONE      = 8'h0f;
  localparam logic [7:0]  WM_EN_ONE        = 8'hcf;
  localparam logic [7:0]  WM_EN_TWO        = 8'hd0;
  localparam logic [7:0]  WM_FLAG_ONE      = 8'hcf;
  localparam logic [7:0]  WM_FLAG_TWO      = 8'hd0;
  localparam logic [7:0]  WM_ALL           = 8'hff;
  localparam int          BIT_TB1          = 7;
  localparam int          BIT_TA           = 6;
  // External pins that also feed the timer and converter edge outputs.
  localparam int          BIT_TIMER_Y      = 7;
  localparam int          BIT_TIMER_B      = 6;
  localparam int          BIT_CONV_TRIG    = 5;
  localparam int          NUM_REQ_PINS     = 4;
  localparam int          NUM_EXT_PINS     = 8;
endpackage

//--- iec_edge_detect.sv
// Synchroniser and selectable edge detector for a group of pins.
// Assumes pins are synchronous to clk per the house pin rule.
`timescale 1ns/1ps
`default_nettype none
module iec_edge_detect #(
  parameter int N = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [N-1:0] pin,
  input  wire logic [N-1:0] rise_sel,
  output logic      [N-1:0] edge_pulse
);
  logic [N-1:0] sync1_r;
  logic [N-1:0] sync2_r;
  logic [N-1:0] prev_r;

  // Pins idle high, so reset the stages high to avoid a false fall.
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= '1;
      sync2_r <= '1;
      prev_r  <= '1;
    end else begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_edge
      // One set of current and previous samples gives one pulse per edge.
      assign edge_pulse[i] = rise_sel[i] ? (sync2_r[i] & ~prev_r[i])
                                         : (~sync2_r[i] & prev_r[i]);
    end
  endgenerate
endmodule
`default_nettype wire

//--- iec_flag_reg.sv
// One eight-bit request flag register with write-zero-to-clear bits.
// Assumes set pulses last one cycle and writes come from the register port.
`timescale 1ns/1ps
`default_nettype none
module iec_flag_reg #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WMASK   = 8'hff
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] set,
  output logic      [7:0] flags_r
);
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_r <= RST_VAL;
    end else begin
      // A set arriving with a clearing write wins, so no event is lost.
      // Acceptance by the CPU never clears a flag.
      flags_r <= (((wr ? (flags_r & (wdata | ~WMASK)) : flags_r)
                  | (set & WMASK)) & WMASK) | (RST_VAL & ~WMASK);
    end
  end
endmodule
`default_nettype wire

//--- iec_checker.sv
// Checker for the interrupt edge and enable control block.
// Assumes it is bound to iec_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module iec_checker
  import iec_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst,
  input wire logic [AW-1:0] addr,
  input wire logic          wr_stb,
  input wire logic          rd_stb,
  input wire logic [7:0]    rdata,
  input wire logic          cpu_mask,
  input wire logic [7:0]    pending_one,
  input wire logic [7:0]    pending_two,
  input wire logic [7:0]    pending_three,
  input wire logic          cpu_irq,
  input wire logic          timer_y_clock_edge,
  input wire logic          timer_b_clock_edge,
  input wire logic          converter_trigger_edge
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_irq; cpu_irq == ((|{pending_one, pending_two, pending_three}) && !cpu_mask); endproperty
  a_irq: assert property (p_irq) else $error("cpu_irq disagrees with pending");
  property p_mask; cpu_mask |-> !cpu_irq; endproperty
  a_mask: assert property (p_mask) else $error("cpu_irq high while masked");
  property p_rd_idle; !$past(rd_stb) |-> rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero when idle");
  property p_rd_e1; rd_stb && addr == ADDR_EDGE_ONE |=> rdata[7:4] == 4'h7; endproperty
  a_rd_e1: assert property (p_rd_e1) else $error("edge select fixed bits wrong");
  property p_rd_en1; rd_stb && addr == ADDR_EN_ONE |=> rdata[5:4] == 2'b01; endproperty
  a_rd_en1: assert property (p_rd_en1) else $error("enable fixed bits wrong");
  property p_rd_f1; rd_stb && addr == ADDR_FLAG_ONE |=> rdata[5:4] == 2'b01; endproperty
  a_rd_f1: assert property (p_rd_f1) else $error("flag fixed bits wrong");
  property p_unmap; rd_stb && addr < ADDR_EDGE_ONE |=> rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_keep;
    !(wr_stb && (addr == ADDR_FLAG_ONE || addr == ADDR_EN_ONE))
      |=> (pending_one & $past(pending_one)) == $past(pending_one);
  endproperty
  a_keep: assert property (p_keep) else $error("pending flag dropped");
  property p_ty; timer_y_clock_edge |=> !timer_y_clock_edge; endproperty
  a_ty: assert property (p_ty) else $error("timer y edge too long");
  property p_tb; timer_b_clock_edge |=> !timer_b_clock_edge; endproperty
  a_tb: assert property (p_tb) else $error("timer b edge too long");
  property p_cv; converter_trigger_edge |=> !converter_trigger_edge; endproperty
  a_cv: assert property (p_cv) else $error("trigger edge too long");
  c_irq: cover property (cpu_irq);
  c_ty: cover property (timer_y_clock_edge);
  c_mask: cover property (cpu_mask && |pending_one);
endmodule
bind iec_top iec_checker u_chk (.clk, .rst, .addr, .wr_stb, .rd_stb, .rdata, .cpu_mask,
  .pending_one, .pending_two, .pending_three, .cpu_irq, .timer_y_clock_edge,
  .timer_b_clock_edge, .converter_trigger_edge);
`default_nettype wire

//--- iec_pin_model.sv
// External request pins as seen from outside the block.
// Assumes the bench asks for pin levels; pins idle high and follow one edge later.
`timescale 1ns/1ps
`default_nettype none
module iec_pin_model (
  input  wire logic       clk,
  input  wire logic [3:0] req_lvl,
  input  wire logic [7:0] ext_lvl,
  output logic      [3:0] req_pin,
  output logic      [7:0] ext_pin
);
  initial begin
    req_pin = 4'hf;
    ext_pin = 8'hff;
  end
  always @(posedge clk) begin
    req_pin <= req_lvl;
    ext_pin <= ext_lvl;
  end
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the interrupt edge and enable control block.
// Assumes the pin model and the checker bound to iec_top.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import iec_pkg::*;
  logic        clk = 0, rst = 1, wr_stb = 0, rd_stb = 0, cpu_mask = 0;
  logic        timer_b1_ovf = 0, timer_a_ovf = 0, cpu_irq;
  logic        timer_y_clock_edge, timer_b_clock_edge, converter_trigger_edge;
  logic [15:0] addr = 16'h0000;
  logic [7:0]  wdata = 8'h00, set_two = 8'h00, set_three = 8'h00, ext_lvl = 8'hff;
  logic [7:0]  rdata, pending_one, pending_two, pending_three, ext_pin, got, d;
  logic [7:0]  ny = 0, nb = 0, nc = 0;
  logic [3:0]  req_lvl = 4'hf, req_pin;
  logic [31:0] seed = 32'h15fbc4d2;
  logic [7:0]  rv [8] = '{8'h70, 8'h00, 8'h10, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00};
  int          errors = 0, n_tests = 0;
  always #4 clk = ~clk;
  iec_pin_model u_pins (.clk, .req_lvl, .ext_lvl, .req_pin, .ext_pin);
  iec_top DUT (.clk, .rst, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .req_pin, .ext_pin,
    .timer_b1_ovf, .timer_a_ovf, .set_two, .set_three, .cpu_mask, .timer_y_clock_edge,
    .timer_b_clock_edge, .converter_trigger_edge, .pending_one, .pending_two,
    .pending_three, .cpu_irq);
  always @(posedge clk) begin
    ny <= ny + {7'h0, timer_y_clock_edge};
    nb <= nb + {7'h0, timer_b_clock_edge};
    nc <= nc + {7'h0, converter_trigger_edge};
  end
  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] nx(input logic [31:0] s);
    nx = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  function automatic logic [7:0] rb(input int i, input logic [7:0] v);
    case (i)
      0: rb = 8'h70 | (v & 8'h0f);
      2: rb = 8'h10 | (v & 8'hcf);
      3: rb = v & 8'hd0;
      default: rb = v;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  task automatic summarize;
    $display("comparisons %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    summarize();
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rd(16'hfff2 + 16'(i), got);
      chk("reset value", got, rv[i]);
    end
    rd(16'hfff1, got);
    chk("unmapped", got, 8'h00);
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 3; k++) begin
        seed = nx(seed);
        d = (k == 0) ? 8'hff : ((k == 1) ? 8'h00 : seed[7:0]);
        wr(16'hfff2 + 16'(i), d);
        rd(16'hfff2 + 16'(i), got);
        chk("read back", got, rb(i, d));
      end
    end
    wr(16'hfff2, 8'h00);
    wr(16'hfff3, 8'he0);
    wr(16'hfff4, 8'hc1);
    wr(16'hfff7, 8'hff);
    rd(16'hfff7, got);
    chk("flag write one", got, 8'h10);
    req_lvl <= 4'he;
    repeat (6) @(posedge clk);
    rd(16'hfff7, got);
    chk("falling flag", got, 8'h11);
    chk("irq", {7'h0, cpu_irq}, 8'h01);
    cpu_mask <= 1'b1;
    repeat (2) @(posedge clk);
    chk("masked irq", {7'h0, cpu_irq}, 8'h00);
    req_lvl <= 4'hf;
    repeat (6) @(posedge clk);
    rd(16'hfff7, got);
    chk("flag held", got, 8'h11);
    cpu_mask <= 1'b0;
    wr(16'hfff7, 8'h10);
    rd(16'hfff7, got);
    chk("flag cleared", got, 8'h10);
    wr(16'hfff2, 8'h0f);
    req_lvl <= 4'h0;
    repeat (6) @(posedge clk);
    rd(16'hfff7, got);
    chk("rising only", got, 8'h10);
    req_lvl <= 4'hf;
    repeat (6) @(posedge clk);
    rd(16'hfff7, got);
    chk("rising flags", got, 8'h1f);
    wr(16'hfff7, 8'h00);
    timer_b1_ovf <= 1'b1;
    timer_a_ovf <= 1'b1;
    @(posedge clk);
    timer_b1_ovf <= 1'b0;
    timer_a_ovf <= 1'b0;
    repeat (3) @(posedge clk);
    chk("timer pending", pending_one, 8'hc0);
    wr(16'hfff4, 8'h10);
    chk("timer gated", pending_one, 8'h00);
    ext_lvl <= 8'h00;
    repeat (6) @(posedge clk);
    ext_lvl <= 8'hff;
    repeat (8) @(posedge clk);
    rd(16'hfff9, got);
    chk("ext flags", got, 8'hff);
    seed = nx(seed);
    wr(16'hfff6, seed[7:0]);
    chk("pending three", pending_three, seed[7:0]);
    chk("timer y edges", ny, 8'h01);
    chk("timer b edges", nb, 8'h01);
    chk("trigger edges", nc, 8'h01);
    seed = nx(seed);
    set_two <= seed[7:0];
    @(posedge clk);
    set_two <= 8'h00;
    repeat (3) @(posedge clk);
    rd(16'hfff8, got);
    chk("flags two", got, seed[7:0] & 8'hd0);
    wr(16'hfff5, 8'hff);
    chk("pending two", pending_two, seed[7:0] & 8'hd0);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(16'hfff9, got);
    chk("flags after reset", got, 8'h00);
    rd(16'hfff2, got);
    chk("edge after reset", got, 8'h70);
    summarize();
  end
endmodule
`default_nettype wire
